// [center_aligned_pwm_state_fsm_bench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cpwm_params.svh"

module center_aligned_pwm_state_fsm_bench;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h00000000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic gateClr = 1'b1;
  logic [31:0] regRdata;
  logic [7:0] dataLines;
  logic [4:0] timerObs;
  logic [15:0] hiRises;
  logic strayLine;
  logic [31:0] rd;
  int n_errors = 0;
  int n_compared = 0;

  // ----------------------------------------
  // clock, design and far side
  // ----------------------------------------
  always #50 clk_sys = ~clk_sys;

  cpwm_top dut (
    .clk_sys(clk_sys),
    .srst(srst),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWr(regWr),
    .regRd(regRd),
    .regRdata(regRdata),
    .dataLines(dataLines),
    .timerObs(timerObs)
  );

  cpwm_gate_model gates (
    .clk_sys(clk_sys),
    .clr(gateClr),
    .lines(dataLines),
    .hiRises(hiRises),
    .strayLine(strayLine)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample there
  task automatic reg_read(logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask

  task automatic clear_gates();
    @(posedge clk_sys);
    gateClr <= 1'b1;
    @(posedge clk_sys);
    gateClr <= 1'b0;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_values();
    logic [31:0] cmpExp [5];
    cmpExp = '{32'd49, 32'd4, 32'd149, 32'd4, 32'd199};
    check("lines after reset", 32'h0, {24'h0, dataLines});
    check("timers after reset", 32'h0, {27'h0, timerObs});
    reg_read(`CPWM_A_CTRL, rd);
    check("ctrl reset", 32'h0, rd);
    reg_read(`CPWM_A_MODE, rd);
    check("mode reset", 32'h00006db6, rd);
    for (int i = 0; i < 5; i++) begin
      reg_read(`CPWM_A_CMP0 + 8'(4 * i), rd);
      check("compare reset", cmpExp[i], rd);
    end
    reg_read(`CPWM_A_STAT, rd);
    check("pointer reset", 32'h0, {29'h0, rd[2:0]});
    reg_read(8'h0c, rd);
    check("unmapped read", 32'h0, rd);
    reg_read(`CPWM_A_WORD0, rd);
    check("word write only", 32'h0, rd);
  endtask

  // two full periods: high/low pairs 10,11,10,00 repeat, period set by timer 4
  task automatic t_walk();
    logic [7:0] exp [4];
    logic [7:0] last;
    logic t4Last;
    int cnt;
    int k;
    int t0;
    int r4;
    exp = '{8'h01, 8'h03, 8'h01, 8'h00};
    clear_gates();
    reg_write(`CPWM_A_CTRL, 32'h1);
    last = 8'h00;
    t4Last = 1'b0;
    cnt = 0;
    k = 0;
    t0 = 0;
    r4 = 0;
    while (k < 8 && cnt < 3000) begin
      @(posedge clk_sys);
      #1;
      cnt++;
      if (timerObs[4] && !t4Last) begin
        if (r4 > 0) check("timer4 period", 32'd400, 32'(cnt - r4));
        r4 = cnt;
      end
      t4Last = timerObs[4];
      if (dataLines !== last) begin
        check("state lines", {24'h0, exp[k % 4]}, {24'h0, dataLines});
        if (k == 0) t0 = cnt;
        if (k == 4) check("pwm period", 32'd400, 32'(cnt - t0));
        last = dataLines;
        k++;
      end
    end
    check("line changes", 32'd8, 32'(k));
    check("high side pulses", 32'h2, {16'h0, hiRises});
    check("masked lines", 32'h0, {31'h0, strayLine});
    reg_read(`CPWM_A_STAT, rd);
    check("running", 32'h1, {31'h0, rd[16]});
    check("unit flag", 32'h1 << rd[2:0], {27'h0, rd[12:8]});
  endtask

  task automatic t_disable();
    reg_write(`CPWM_A_CTRL, 32'h0);
    repeat (5) @(posedge clk_sys);
    #1;
    check("lines off", 32'h0, {24'h0, dataLines});
    check("timers off", 32'h0, {27'h0, timerObs});
    reg_read(`CPWM_A_STAT, rd);
    check("pointer idle", 32'h0, {15'h0, rd[16], 13'h0, rd[2:0]});
  endtask

  // unit 0 taken out of state mode: pointer must hold and lines stay low
  task automatic t_mode_gate();
    reg_write(`CPWM_A_MODE, 32'h00006db0);
    clear_gates();
    reg_write(`CPWM_A_CTRL, 32'h1);
    repeat (1000) @(posedge clk_sys);
    check("gated pulses", 32'h0, {16'h0, hiRises});
    reg_read(`CPWM_A_STAT, rd);
    check("gated pointer", 32'h0, {29'h0, rd[2:0]});
    t_disable();
    reg_write(`CPWM_A_MODE, 32'h00006db6);
  endtask

  // ----------------------------------------
  // verdict, watchdog and main sequence
  // ----------------------------------------
  task automatic print_verdict();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // the whole run needs under 8000 cycles
  initial begin
    #(20000 * 100);
    n_errors++;
    $display("CHECK FAILED watchdog expected done seen hang");
    print_verdict();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_reset_values();
    t_walk();
    t_disable();
    t_mode_gate();
    // drive masked lines from state 0: the walk must not change
    reg_write(`CPWM_A_WORD0, 32'hfc000001);
    t_walk();
    t_disable();
    print_verdict();
  end
endmodule // center_aligned_pwm_state_fsm_bench

`default_nettype wire

// [cpwm_gate_model.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cpwm_params.svh"

// ----------------------------------------
// half-bridge gate drivers on the state lines
// ----------------------------------------
module cpwm_gate_model (
  input wire logic clk_sys,
  input wire logic clr,
  input wire logic [`CPWM_LINES-1:0] lines,
  output logic [15:0] hiRises,
  output logic strayLine
);
  logic hiPrev_q;

  // count high-side turn-on events; sticky flag if a masked line ever moves
  always_ff @(posedge clk_sys) begin
    hiPrev_q <= lines[0];
    if (clr) begin
      hiRises <= 16'h0000;
      strayLine <= 1'b0;
    end else begin
      if (lines[0] && !hiPrev_q) begin
        hiRises <= hiRises + 16'h0001;
      end
      if (|lines[7:2]) begin
        strayLine <= 1'b1;
      end
    end
  end
endmodule // cpwm_gate_model

`default_nettype wire

// [cpwm_params.svh]
`ifndef CPWM_PARAMS_SVH
`define CPWM_PARAMS_SVH

// ----------------------------------------
// structure
// ----------------------------------------
`define CPWM_UNITS 5
`define CPWM_PTR_W 3
`define CPWM_CMP_W 16
`define CPWM_LINES 8
`define CPWM_LINE_MASK 8'h03
`define CPWM_MODE_STATE 3'h6
`define CPWM_MODE_RST 15'h6db6
`define CPWM_IN_GROUP 3'h0
`define CPWM_LAST_UNIT 3'h4
`define CPWM_PTR_RST 3'h0

// ----------------------------------------
// timing: rates in bit/s, timer clock in Hz
// ----------------------------------------
`define CPWM_TCLK_HZ 150000000
`define CPWM_RATE0 1500000
`define CPWM_RATE1 15000000
`define CPWM_RATE2 500000
`define CPWM_RATE3 15000000
`define CPWM_RATE4 375000
`define CPWM_CMP_OF(r) (`CPWM_TCLK_HZ / (2 * (r)) - 1)

// ----------------------------------------
// state word reset values: lines [31:24], next [2:0]
// ----------------------------------------
`define CPWM_WORD0 32'h00000001
`define CPWM_WORD1 32'h01000002
`define CPWM_WORD2 32'h03000003
`define CPWM_WORD3 32'h01000004
`define CPWM_WORD4 32'h00000000

// ----------------------------------------
// register map (byte addresses) and fields
// ----------------------------------------
`define CPWM_A_CTRL 8'h00
`define CPWM_A_STAT 8'h04
`define CPWM_A_MODE 8'h08
`define CPWM_A_CMP0 8'h10
`define CPWM_A_CMPN 8'h20
`define CPWM_A_WORD0 8'h40
`define CPWM_A_WORDN 8'h50
`define CPWM_CTRL_EN 0

`endif

// [cpwm_pkg.sv]
package cpwm_pkg;
  // run control, gray coded along idle -> prime -> run
  typedef enum logic [1:0] {
    CPWM_IDLE = 2'h0,
    CPWM_PRIME = 2'h1,
    CPWM_RUN = 2'h3
  } cpwm_run_t;

  // one state word as held per unit
  typedef struct packed {
    logic [7:0] lines;
    logic [23:0] nextSel;
  } cpwm_word_t;
endpackage

// [cpwm_state_mem.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cpwm_params.svh"

module cpwm_state_mem (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic wrEn,
  input wire logic [`CPWM_PTR_W-1:0] wrIdx,
  input wire logic [31:0] wrData,
  input wire logic [`CPWM_PTR_W-1:0] rdIdx,
  output cpwm_pkg::cpwm_word_t rdData
);
  localparam logic [32*`CPWM_UNITS-1:0] RST =
    {`CPWM_WORD4, `CPWM_WORD3, `CPWM_WORD2, `CPWM_WORD1, `CPWM_WORD0};

  logic [31:0] word_q [`CPWM_UNITS];
  cpwm_pkg::cpwm_word_t rd_q;

  // ----------------------------------------
  // storage, one entry per unit
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < `CPWM_UNITS; i++) begin : g_ent
      always_ff @(posedge clk_sys) begin
        if (srst)
          word_q[i] <= RST[32*i +: 32];
        else if (wrEn && wrIdx == i[`CPWM_PTR_W-1:0])
          word_q[i] <= wrData;
      end
    end
  endgenerate

  // registered read; an index past the last unit reads zero
  always_ff @(posedge clk_sys) begin
    if (srst)
      rd_q <= '0;
    else if (rdIdx <= `CPWM_LAST_UNIT)
      rd_q <= word_q[rdIdx];
    else
      rd_q <= '0;
  end

  assign rdData = rd_q;
endmodule // cpwm_state_mem
`default_nettype wire

// [cpwm_timer.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cpwm_params.svh"

module cpwm_timer (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic run,
  input wire logic trig,
  input wire logic alwaysOn,
  input wire logic initOne,
  input wire logic [`CPWM_CMP_W-1:0] cmp,
  output logic out,
  output logic expire
);
  logic trigPrev_q, on_q, out_q;
  logic [`CPWM_CMP_W-1:0] cnt_q, gapCnt_q;

  // ----------------------------------------
  // trigger edges and counter control
  // ----------------------------------------
  wire trigRise = trig & ~trigPrev_q;
  wire trigFall = ~trig & trigPrev_q;
  wire startNow = run & (alwaysOn ? ~on_q : trigRise);
  wire stopNow = ~run | (~alwaysOn & trigFall);
  wire tick = on_q & (cnt_q == '0);

  // down counter reloads on each toggle, so each half period is cmp + 1 cycles
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      trigPrev_q <= 1'b0;
      on_q <= 1'b0;
      out_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      trigPrev_q <= trig;
      if (stopNow) begin
        on_q <= 1'b0; // RULE_13
        out_q <= out_q & run;
      end else if (startNow) begin
        on_q <= 1'b1; // RULE_13
        cnt_q <= cmp;
        out_q <= initOne; // RULE_14
      end else if (tick) begin
        cnt_q <= cmp; // RULE_22
        out_q <= ~out_q; // RULE_08
      end else if (on_q) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign out = out_q;
  assign expire = tick;

  // cycles since start or last toggle, only for checking
  always_ff @(posedge clk_sys) begin
    if (srst || startNow || tick)
      gapCnt_q <= '0;
    else
      gapCnt_q <= gapCnt_q + 1'b1;
  end

  a_toggle_period: assert property (@(posedge clk_sys) disable iff (srst) // RULE_22
    (tick && $past(on_q) && $stable(cmp)) |-> gapCnt_q == cmp)
    else $error("timer toggled off its compare period");

  a_start_level: assert property (@(posedge clk_sys) disable iff (srst) // RULE_14
    (startNow && !stopNow) |=> (on_q && out_q == $past(initOne) && cnt_q == $past(cmp)))
    else $error("timer did not start at its initial level");

  a_stop_fall: assert property (@(posedge clk_sys) disable iff (srst) // RULE_13
    (trigFall && !alwaysOn) |=> !on_q)
    else $error("timer kept running after trigger fell");
endmodule // cpwm_timer
`default_nettype wire

// [cpwm_top.sv]
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "cpwm_params.svh"

// Overview of operation
// RULE_01 - complementary centered pwm pair with dead time, five states per period
// RULE_02 - outputs high/low per state: 00, 10, 11, 10, 00
// RULE_03 - alternate line table conflicts; default words follow the pin table
// RULE_04 - next state walks 0,1,2,3,4 then back to 0
// RULE_05 - the three state inputs are tied low, group 0 always chosen
// RULE_06 - state n is stepped by timer n, positive polarity
// RULE_07 - only data lines 0 and 1 driven, lines 2 to 7 masked
// RULE_08 - every timer runs as a single 16-bit counter
// RULE_09 - pulse count bounded by enable and disable triggers, not extra timers
// RULE_10 - baud mode: low byte sets rate, high byte sets edge count
// RULE_11 - high pwm mode: low byte sets high time, high byte low time
// RULE_12 - triggers: t0 t4 high, t2 t4 low, t1 line1 low, t3 line0 low
// RULE_13 - timers 0-3 start on trigger rise, stop on fall; timer 4 free
// RULE_14 - on enable timers 0-3 output zero, timer 4 outputs one
// RULE_15 - compare values 49, 4, 149, 4, 199
// RULE_16 - rates 1.5M, 15M, 500k, 15M, 375k bit/s
// RULE_17 - each timer output visible on its own observation line
// RULE_18 - state steps when the selected timer expires
// RULE_19 - word bits 31:24 drive lines, group 0 next state in bits 2:0
// RULE_20 - a unit acts as a state element only with mode field 110b
// RULE_21 - unit flag set while the pointer selects it, cleared otherwise
// RULE_22 - 16-bit counter output toggles every compare plus one cycles
// RULE_23 - after reset pointer at state 0, lines low, timers wait for enable

module cpwm_top (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic [`CPWM_LINES-1:0] dataLines,
  output logic [`CPWM_UNITS-1:0] timerObs
);
  localparam int N = `CPWM_UNITS;
  localparam int PW = `CPWM_PTR_W;

  // compare defaults derived from the wanted rates
  localparam logic [16*N-1:0] CMP_RST = { // RULE_15 RULE_16
    16'(`CPWM_CMP_OF(`CPWM_RATE4)),
    16'(`CPWM_CMP_OF(`CPWM_RATE3)),
    16'(`CPWM_CMP_OF(`CPWM_RATE2)),
    16'(`CPWM_CMP_OF(`CPWM_RATE1)),
    16'(`CPWM_CMP_OF(`CPWM_RATE0))};

  cpwm_pkg::cpwm_run_t runSt_q, runSt_d;
  logic enable_q;
  logic [3*N-1:0] mode_q;
  logic [`CPWM_CMP_W-1:0] cmp_q [N];
  logic [PW-1:0] statePtr_q, statePtr_d;
  logic [`CPWM_LINES-1:0] dataLines_q, dataLines_d;
  logic [N-1:0] timerObs_q;
  logic [31:0] regRdata_q, rdMux;
  logic [N-1:0] tmrOut, tmrExpire, tmrTrig;
  cpwm_pkg::cpwm_word_t curWord;

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  wire [7:0] cmpOff = regAddr - `CPWM_A_CMP0;
  wire [7:0] wordOff = regAddr - `CPWM_A_WORD0;
  wire aligned = (regAddr[1:0] == 2'h0);
  wire cmpHit = aligned && regAddr >= `CPWM_A_CMP0 && regAddr <= `CPWM_A_CMPN;
  wire wordHit = aligned && regAddr >= `CPWM_A_WORD0 && regAddr <= `CPWM_A_WORDN;
  wire [PW-1:0] cmpIdx = cmpOff[4:2];
  wire [PW-1:0] wordIdx = wordOff[4:2];
  wire ctrlWr = regWr && regAddr == `CPWM_A_CTRL;
  wire modeWr = regWr && regAddr == `CPWM_A_MODE;
  wire wordWr = regWr && wordHit;

  // control register: block enable
  always_ff @(posedge clk_sys) begin
    if (srst)
      enable_q <= 1'b0; // RULE_23
    else if (ctrlWr)
      enable_q <= regWdata[`CPWM_CTRL_EN];
  end

  // unit mode fields, three bits per unit
  always_ff @(posedge clk_sys) begin
    if (srst)
      mode_q <= `CPWM_MODE_RST;
    else if (modeWr)
      mode_q <= regWdata[3*N-1:0];
  end

  // compare registers, one per timer
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_cmp
      always_ff @(posedge clk_sys) begin
        if (srst)
          cmp_q[i] <= CMP_RST[16*i +: 16]; // RULE_15
        else if (regWr && cmpHit && cmpIdx == i[PW-1:0])
          cmp_q[i] <= regWdata[`CPWM_CMP_W-1:0];
      end
    end
  endgenerate

  // ----------------------------------------
  // run control
  // ----------------------------------------
  wire running = (runSt_q == cpwm_pkg::CPWM_RUN);

  // prime spends one cycle fetching the state 0 word before timers go
  always_comb begin
    case (runSt_q)
      cpwm_pkg::CPWM_IDLE:
        runSt_d = enable_q ? cpwm_pkg::CPWM_PRIME : cpwm_pkg::CPWM_IDLE;
      cpwm_pkg::CPWM_PRIME:
        runSt_d = enable_q ? cpwm_pkg::CPWM_RUN : cpwm_pkg::CPWM_IDLE;
      cpwm_pkg::CPWM_RUN:
        runSt_d = enable_q ? cpwm_pkg::CPWM_RUN : cpwm_pkg::CPWM_IDLE;
      default:
        runSt_d = cpwm_pkg::CPWM_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst)
      runSt_q <= cpwm_pkg::CPWM_IDLE;
    else
      runSt_q <= runSt_d;
  end

  // ----------------------------------------
  // state words and next state
  // ----------------------------------------
  // read index is the next pointer, so the word lines up with statePtr_q
  cpwm_state_mem u_mem (
    .clk_sys(clk_sys),
    .srst(srst),
    .wrEn(wordWr),
    .wrIdx(wordIdx),
    .wrData(regWdata),
    .rdIdx(statePtr_d),
    .rdData(curWord)
  );

  wire ptrValid = (statePtr_q <= `CPWM_LAST_UNIT);
  wire [2:0] unitMode = ptrValid ? mode_q[3*statePtr_q +: 3] : 3'h0;
  wire stateOk = ptrValid && unitMode == `CPWM_MODE_STATE; // RULE_20
  wire selExpire = ptrValid && tmrExpire[statePtr_q]; // RULE_06
  wire [PW-1:0] nextPtr = curWord.nextSel[3*`CPWM_IN_GROUP +: 3]; // RULE_05 RULE_19
  wire advance = running && stateOk && selExpire; // RULE_18

  // pointer walks the programmed chain; default words give 0..4 and back
  assign statePtr_d = !running && runSt_q != cpwm_pkg::CPWM_PRIME ? `CPWM_PTR_RST
    : advance ? nextPtr : statePtr_q; // RULE_04

  always_ff @(posedge clk_sys) begin
    if (srst)
      statePtr_q <= `CPWM_PTR_RST; // RULE_23
    else
      statePtr_q <= statePtr_d;
  end

  // unit flags: one hot on the selected unit while running
  wire [N-1:0] unitFlags;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      assign unitFlags[i] = running && statePtr_q == i[PW-1:0]; // RULE_21
    end
  endgenerate

  // ----------------------------------------
  // output lines
  // ----------------------------------------
  // masked lines never drive, whatever software writes in the word
  assign dataLines_d = (running && stateOk) ?
    (curWord.lines & `CPWM_LINE_MASK) : '0; // RULE_02 RULE_07

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dataLines_q <= '0;
      timerObs_q <= '0;
    end else begin
      dataLines_q <= dataLines_d; // RULE_01
      timerObs_q <= tmrOut; // RULE_17
    end
  end

  assign dataLines = dataLines_q;
  assign timerObs = timerObs_q;

  // ----------------------------------------
  // timers and their trigger routing
  // ----------------------------------------
  // the lines feed back from the output flops, adding one cycle of
  // lag to timers 1 and 3 that the dead time absorbs; in the alternate
  // line table line 0 is our low side and line 1 the inverted high side,
  // so timer 1 starts as the high side rises and timer 3 as the low side falls
  assign tmrTrig[0] = tmrOut[4]; // RULE_12
  assign tmrTrig[1] = dataLines_q[0]; // RULE_12 RULE_03
  assign tmrTrig[2] = ~tmrOut[4]; // RULE_12
  assign tmrTrig[3] = ~dataLines_q[1]; // RULE_12 RULE_03
  assign tmrTrig[4] = 1'b0;

  // gating by trigger keeps extra pulses out of later states
  generate
    for (i = 0; i < N; i++) begin : g_tmr
      cpwm_timer u_tmr (
        .clk_sys(clk_sys),
        .srst(srst),
        .run(running), // RULE_23
        .trig(tmrTrig[i]), // RULE_09
        .alwaysOn(i == N - 1), // RULE_13
        .initOne(i == N - 1), // RULE_14
        .cmp(cmp_q[i]), // RULE_08; byte-split modes are not built RULE_10 RULE_11
        .out(tmrOut[i]),
        .expire(tmrExpire[i])
      );
    end
  endgenerate

  // ----------------------------------------
  // register read back
  // ----------------------------------------
  wire [31:0] statWord = {15'h0, running, 3'h0, unitFlags, 5'h0, statePtr_q};
  wire [31:0] cmpWord = cmpHit && cmpIdx <= `CPWM_LAST_UNIT ?
    {16'h0, cmp_q[cmpIdx]} : 32'h0;

  // state words are write only; unmapped addresses read zero
  always_comb begin
    case (regAddr)
      `CPWM_A_CTRL: rdMux = {31'h0, enable_q};
      `CPWM_A_STAT: rdMux = statWord;
      `CPWM_A_MODE: rdMux = {17'h0, mode_q};
      default: rdMux = cmpWord;
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clk_sys) begin
    if (srst)
      regRdata_q <= '0;
    else if (regRd)
      regRdata_q <= rdMux;
    else
      regRdata_q <= '0;
  end

  assign regRdata = regRdata_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_run_start;
    (runSt_q == cpwm_pkg::CPWM_PRIME) ##1 running;
  endsequence

  sequence s_step;
    advance ##1 running;
  endsequence

  a_lines_masked: assert property ( // RULE_07
    (dataLines & ~`CPWM_LINE_MASK) == '0)
    else $error("masked data line driven");

  a_ptr_follows: assert property ( // RULE_19
    s_step |-> statePtr_q == $past(nextPtr))
    else $error("pointer did not take group 0 next state");

  a_step_cause: assert property ( // RULE_18
    (running && $past(running) && $changed(statePtr_q)) |-> $past(selExpire))
    else $error("state changed without its timer expiring");

  a_flag_onehot: assert property ( // RULE_21
    (running && ptrValid) |-> ($onehot(unitFlags) && unitFlags[statePtr_q]))
    else $error("unit flag does not match pointer");

  a_mode_gate: assert property ( // RULE_20
    (running && !stateOk && enable_q) |=> $stable(statePtr_q))
    else $error("non state unit moved the pointer");

  a_t4_first: assert property ( // RULE_14
    s_run_start |-> ##1 (tmrOut[4] && !tmrOut[0]) ##1 !tmrOut[0])
    else $error("timer start levels wrong");

  a_idle_quiet: assert property ( // RULE_23
    (!running ##1 !running) |-> (dataLines == '0 && statePtr_q == `CPWM_PTR_RST))
    else $error("lines or pointer active while stopped");

  a_lines_lag: assert property ( // RULE_02
    (running && stateOk && $stable(curWord)) ##1 running |->
      dataLines == ($past(curWord.lines) & `CPWM_LINE_MASK))
    else $error("lines do not follow state word");

  a_rd_once: assert property ( // strobed register access, decided for this implementation
    !$past(regRd) |-> regRdata == '0)
    else $error("read data outside its cycle");
endmodule // cpwm_top
`default_nettype wire
